// ### src/apr_pkg.sv
package apr_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned CONV_PULSE_NS = 5000;
   // a least time, so round up to whole clock cycles
   localparam int unsigned CONV_PULSE_CYC_I = (CONV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CW = 7;
   localparam logic [PULSE_CW-1:0] CONV_PULSE_CYC = PULSE_CW'(CONV_PULSE_CYC_I);
   localparam logic [PULSE_CW-1:0] PULSE_CNT_ZERO = 7'h00;
   localparam logic [PULSE_CW-1:0] PULSE_CNT_ONE = 7'h01;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int REG_AW = 8;
   localparam int ROUTE_W = 24;
   localparam logic [REG_AW-1:0] ROUTE_MASK_ADDR = 8'h27;
   localparam logic [ROUTE_W-1:0] ROUTE_MASK_RESET = 24'h000000;
   localparam logic [ROUTE_W-1:0] ROUTE_MASK_WRITABLE = 24'hfffffe;
   localparam logic [ROUTE_W-1:0] ROUTE_ZERO = 24'h000000;

   // ------------------------------------------------------------
   // field positions of the routing mask
   // ------------------------------------------------------------
   localparam int OVERCUR_MSB = 23;
   localparam int UNDERCUR_MSB = 19;
   localparam int OVERVOLT_MSB = 15;
   localparam int UNDERVOLT_MSB = 11;
   localparam int OVERPWR_MSB = 7;
   localparam int ACCUM_FULL_BIT = 3;
   localparam int COUNT_FULL_BIT = 2;
   localparam int CONV_DONE_BIT = 1;
   localparam int UNUSED_BIT = 0;

   // ------------------------------------------------------------
   // pulse state machine
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      APR_PULSE_IDLE = 2'b01,
      APR_PULSE_ON = 2'b10
   } apr_pulse_state_t;

endpackage

// ### src/apr_conv_pulse.sv
`timescale 1ns/1ps
`default_nettype none

module apr_conv_pulse
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic pulse_start,
   input wire logic pulse_abort,
   output logic pulse_active
);

   apr_pkg::apr_pulse_state_t state_r;
   apr_pkg::apr_pulse_state_t state_nxt;
   logic [apr_pkg::PULSE_CW-1:0] cnt_r;
   logic [apr_pkg::PULSE_CW-1:0] cnt_nxt;
   wire logic cnt_done;

   assign cnt_done = (cnt_r == apr_pkg::PULSE_CNT_ZERO);

   // a new completion restarts the full width; the pin never sees a gap
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         apr_pkg::APR_PULSE_IDLE:
         begin
            if (pulse_start)
            begin
               state_nxt = apr_pkg::APR_PULSE_ON;
               cnt_nxt = apr_pkg::CONV_PULSE_CYC - apr_pkg::PULSE_CNT_ONE;
            end
         end
         apr_pkg::APR_PULSE_ON:
         begin
            if (pulse_start)
            begin
               cnt_nxt = apr_pkg::CONV_PULSE_CYC - apr_pkg::PULSE_CNT_ONE;
            end
            else if (pulse_abort || cnt_done)
            begin
               state_nxt = apr_pkg::APR_PULSE_IDLE;
               cnt_nxt = apr_pkg::PULSE_CNT_ZERO;
            end
            else
            begin
               cnt_nxt = cnt_r - apr_pkg::PULSE_CNT_ONE;
            end
         end
         default:
         begin
            state_nxt = apr_pkg::APR_PULSE_IDLE;
            cnt_nxt = apr_pkg::PULSE_CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r <= apr_pkg::APR_PULSE_IDLE;
         cnt_r <= apr_pkg::PULSE_CNT_ZERO;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign pulse_active = (state_r == apr_pkg::APR_PULSE_ON);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   pulse_start_load_a: assert property (pulse_start |=> pulse_active && cnt_r == apr_pkg::CONV_PULSE_CYC - apr_pkg::PULSE_CNT_ONE)
      else $error("pulse not loaded to full width");
   pulse_count_down_a: assert property (pulse_active && !cnt_done && !pulse_start && !pulse_abort
      |=> pulse_active && cnt_r == $past(cnt_r) - apr_pkg::PULSE_CNT_ONE)
      else $error("pulse count did not step down");
   pulse_end_a: assert property (pulse_active && cnt_done && !pulse_start |=> !pulse_active)
      else $error("pulse ran past its width");
   pulse_abort_a: assert property (pulse_abort && !pulse_start |=> !pulse_active)
      else $error("pulse survived loss of alert function");

endmodule // apr_conv_pulse

`default_nettype wire

// ### src/apr_alert1_route.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - overvoltage enables for channels two to four, bits 14..12, gate them onto the pin.
// - undervoltage enables for channels one to four sit in bits 11..8.
// - overpower enables for channels one to four sit in bits 7..4.
// - bit 3 routes any channel accumulator overflow or fullness-limit condition.
// - bit 2 routes sample counter overflow or fullness-limit condition.
// - bit 1 gives a 5 us pin pulse after every completed conversion cycle.
// - the conversion pulse reaches the pin only while the pin is in alert function.
// - in alert function the pin's slow-mode input is ignored.
// - bit 0 does nothing and always reads zero.
// - bits 23..16 route over/undercurrent, bit 15 routes channel one overvoltage.
// - the mask drives the pin only when the pin function selects alert.

module apr_alert1_route
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [apr_pkg::REG_AW-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [apr_pkg::ROUTE_W-1:0] reg_wdata,
   input wire logic reg_rd,
   output logic [apr_pkg::ROUTE_W-1:0] reg_rdata,
   input wire logic [3:0] chan_overcur_trip,
   input wire logic [3:0] chan_undercur_trip,
   input wire logic [3:0] chan_overvolt_trip,
   input wire logic [3:0] chan_undervolt_trip,
   input wire logic [3:0] chan_overpwr_trip,
   input wire logic accum_full_trip,
   input wire logic sample_count_full_trip,
   input wire logic conv_cycle_done,
   input wire logic pin_one_alert_func,
   input wire logic slowctl_alert_pin_one_i,
   output logic slowctl_alert_pin_one_o,
   output logic slowctl_alert_pin_one_oe,
   output logic slow_mode_req
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // trip inputs use bit 0 for channel one; the mask puts channel one on top
   function automatic logic [3:0] chan_to_field(input logic [3:0] v);
      chan_to_field = {v[0], v[1], v[2], v[3]};
   endfunction

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   logic [apr_pkg::ROUTE_W-1:0] route_mask_r;
   logic [apr_pkg::ROUTE_W-1:0] route_mask_nxt;
   logic [apr_pkg::ROUTE_W-1:0] rdata_r;
   logic [apr_pkg::ROUTE_W-1:0] rdata_nxt;
   wire logic addr_hit;
   wire logic mask_wr;
   wire logic mask_rd;

   assign addr_hit = (reg_addr == apr_pkg::ROUTE_MASK_ADDR);
   assign mask_wr = reg_wr && addr_hit;
   assign mask_rd = reg_rd && addr_hit;

   // bit 0 is never stored, so it can only read back as zero
   assign route_mask_nxt = mask_wr ? (reg_wdata & apr_pkg::ROUTE_MASK_WRITABLE) : route_mask_r;
   // other addresses belong to other blocks; this one answers them with zero
   assign rdata_nxt = mask_rd ? route_mask_r : apr_pkg::ROUTE_ZERO;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         route_mask_r <= apr_pkg::ROUTE_MASK_RESET;
      end
      else
      begin
         route_mask_r <= route_mask_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_r <= apr_pkg::ROUTE_ZERO;
      end
      else if (reg_rd)
      begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ------------------------------------------------------------
   // condition routing
   // ------------------------------------------------------------
   wire logic [apr_pkg::ROUTE_W-1:0] cond_vec;
   wire logic [apr_pkg::ROUTE_W-1:0] routed_vec;
   wire logic routed_any;
   wire logic conv_pulse_en;
   wire logic pulse_start;
   wire logic pulse_active;

   // layout follows the mask; the two low bits are not level conditions
   assign cond_vec = {chan_to_field(chan_overcur_trip),
                      chan_to_field(chan_undercur_trip),
                      chan_to_field(chan_overvolt_trip),
                      chan_to_field(chan_undervolt_trip),
                      chan_to_field(chan_overpwr_trip),
                      accum_full_trip,
                      sample_count_full_trip,
                      1'b0,
                      1'b0};
   assign routed_vec = route_mask_r & cond_vec;
   assign routed_any = |routed_vec;

   assign conv_pulse_en = route_mask_r[apr_pkg::CONV_DONE_BIT];
   assign pulse_start = conv_cycle_done && conv_pulse_en && pin_one_alert_func;

   apr_conv_pulse u_conv_pulse
   (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pulse_start(pulse_start),
      .pulse_abort(!pin_one_alert_func),
      .pulse_active(pulse_active)
   );

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   logic alert_r;
   logic slow_req_r;
   wire logic alert_nxt;
   wire logic slow_req_nxt;

   // the mask has no say unless the pin function selects alert
   assign alert_nxt = pin_one_alert_func && (routed_any || pulse_active);
   // slow function would fight the alert drive, so it is dropped outright
   assign slow_req_nxt = !pin_one_alert_func && slowctl_alert_pin_one_i;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         alert_r <= 1'b0;
         slow_req_r <= 1'b0;
      end
      else
      begin
         alert_r <= alert_nxt;
         slow_req_r <= slow_req_nxt;
      end
   end

   // open-drain, active low: pull the wire low only while alerting
   assign slowctl_alert_pin_one_o = 1'b0;
   assign slowctl_alert_pin_one_oe = alert_r;
   assign slow_mode_req = slow_req_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence conv_seen_s;
      pulse_start ##1 pin_one_alert_func;
   endsequence

   // the pin may leave alert function at any time, so only cycles it stays are judged
   sequence func_kept_s;
      (pin_one_alert_func && !pulse_start) [*8];
   endsequence

   mask_write_a: assert property (mask_wr |=> route_mask_r == ($past(reg_wdata) & 24'hfffffe))
      else $error("routing mask did not take the write");
   mask_bit0_a: assert property (!route_mask_r[0] && !reg_rdata[0])
      else $error("unused mask bit is not zero");
   mask_read_a: assert property (mask_rd |=> reg_rdata == $past(route_mask_r))
      else $error("read data do not show the mask");
   ov_route_a: assert property (pin_one_alert_func && route_mask_r[14] && chan_overvolt_trip[1]
      |=> slowctl_alert_pin_one_oe)
      else $error("channel two overvoltage not routed");
   uv_route_a: assert property (pin_one_alert_func && route_mask_r[8] && chan_undervolt_trip[3]
      |=> slowctl_alert_pin_one_oe)
      else $error("channel four undervoltage not routed");
   op_route_a: assert property (pin_one_alert_func && route_mask_r[7] && chan_overpwr_trip[0]
      |=> slowctl_alert_pin_one_oe)
      else $error("channel one overpower not routed");
   accum_route_a: assert property (pin_one_alert_func && route_mask_r[3] && accum_full_trip
      |=> slowctl_alert_pin_one_oe)
      else $error("accumulator fullness not routed");
   count_route_a: assert property (pin_one_alert_func && route_mask_r[2] && sample_count_full_trip
      |=> slowctl_alert_pin_one_oe)
      else $error("sample count fullness not routed");
   cur_route_a: assert property (pin_one_alert_func && route_mask_r[23] && chan_overcur_trip[0]
      |=> slowctl_alert_pin_one_oe)
      else $error("channel one overcurrent not routed");
   conv_pulse_a: assert property (conv_seen_s |=> slowctl_alert_pin_one_oe)
      else $error("conversion pulse missing at the pin");
   conv_width_a: assert property (pulse_start ##1 func_kept_s
      |-> pulse_active ##1 slowctl_alert_pin_one_oe)
      else $error("conversion pulse shorter than expected");
   pulse_pin_a: assert property (pulse_active && pin_one_alert_func |=> slowctl_alert_pin_one_oe)
      else $error("running conversion pulse not on the pin");
   func_gate_a: assert property (!pin_one_alert_func |=> !slowctl_alert_pin_one_oe)
      else $error("pin driven outside alert function");
   slow_ignore_a: assert property (pin_one_alert_func |=> !slow_mode_req)
      else $error("slow input honoured in alert function");
   idle_release_a: assert property (routed_vec == 24'h000000 && !pulse_active
      |=> !slowctl_alert_pin_one_oe)
      else $error("pin asserted with nothing routed");
   any_route_a: assert property (pin_one_alert_func && routed_any |=> slowctl_alert_pin_one_oe)
      else $error("tripped routed condition not on the pin");

endmodule // apr_alert1_route

`default_nettype wire

// ### verification/apr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module apr_host_model
(
   input wire logic pin_o,
   input wire logic pin_oe,
   input wire logic host_pull_low,
   output logic pin_level,
   output logic alert_seen
);
   // ------------------------------------------------------------
   // open-drain line with pull-up
   // ------------------------------------------------------------
   // released line floats up unless host_pull_low holds it low, which then reads as alert
   assign pin_level = pin_oe ? pin_o : !host_pull_low;
   assign alert_seen = !pin_level;
endmodule // apr_host_model

`default_nettype wire

// ### verification/test_alert1_pin_routing_mask.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module test_alert1_pin_routing_mask;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [23:0] reg_wdata = 24'h000000;
   logic [23:0] reg_rdata;
   logic [3:0] oc = 4'h0, uc = 4'h0, ov = 4'h0, uv = 4'h0, op = 4'h0;
   logic acc = 1'b0, cnt = 1'b0, conv_done = 1'b0, func = 1'b1, host_low = 1'b0;
   logic pin_o, pin_oe, slow_req, pin_level, alert_seen;
   logic [31:0] rng = 32'h231a033d;
   logic [23:0] m, c, bitv;
   logic [6:0] hi_cnt;
   int mismatches = 0;
   int n_compared = 0;

   initial
   begin
      forever #25 ref_clk = ~ref_clk;
   end

   apr_alert1_route dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_overcur_trip(oc),
      .chan_undercur_trip(uc), .chan_overvolt_trip(ov), .chan_undervolt_trip(uv), .chan_overpwr_trip(op),
      .accum_full_trip(acc), .sample_count_full_trip(cnt), .conv_cycle_done(conv_done),
      .pin_one_alert_func(func), .slowctl_alert_pin_one_i(pin_level), .slowctl_alert_pin_one_o(pin_o),
      .slowctl_alert_pin_one_oe(pin_oe), .slow_mode_req(slow_req));

   apr_host_model host_u (.pin_o(pin_o), .pin_oe(pin_oe), .host_pull_low(host_low),
      .pin_level(pin_level), .alert_seen(alert_seen));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // expected pin state: routed conditions only, bits 1..0 never trip by level
   function automatic logic exp_alert(input logic [23:0] mk, input logic [23:0] cd, input logic f);
      return f && (|(mk & cd & 24'hfffffc));
   endfunction

   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
      // idle edge, so a following strobe is not reassigned in the same step
      tick;
   endtask

   task automatic rd(input logic [7:0] a, input logic [23:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      tick;
      reg_rd = 1'b0;
      `CHK(reg_rdata, e)
      tick;
   endtask

   // mask bit layout: ch1 at the high bit of each nibble
   task automatic drive_cond(input logic [23:0] cv);
      for (int k = 0; k < 4; k++)
      begin
         oc[k] = cv[23-k];
         uc[k] = cv[19-k];
         ov[k] = cv[15-k];
         uv[k] = cv[11-k];
         op[k] = cv[7-k];
      end
      acc = cv[3];
      cnt = cv[2];
   endtask

   task automatic pulse_count(output logic [6:0] n);
      conv_done = 1'b1;
      tick;
      conv_done = 1'b0;
      n = 7'h00;
      repeat (150)
      begin
         if (alert_seen === 1'b1)
            n++;
         tick;
      end
   endtask

   task automatic end_sim;
      if (mismatches == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      rd(apr_pkg::ROUTE_MASK_ADDR, apr_pkg::ROUTE_MASK_RESET);
      `CHK(alert_seen, 1'b0)
      // ------------------------------------------------------------
      // one condition at a time, routed then blocked
      // ------------------------------------------------------------
      for (int b = 2; b < 24; b++)
      begin
         bitv = 24'h000001 << b;
         wr(apr_pkg::ROUTE_MASK_ADDR, bitv);
         drive_cond(bitv);
         tick;
         `CHK(alert_seen, 1'b1)
         drive_cond(~bitv);
         tick;
         `CHK(alert_seen, 1'b0)
         wr(apr_pkg::ROUTE_MASK_ADDR, ~bitv & 24'hfffffc);
         drive_cond(bitv);
         tick;
         `CHK(alert_seen, 1'b0)
      end
      // ------------------------------------------------------------
      // random masks, conditions, pin function and stray accesses
      // ------------------------------------------------------------
      for (int i = 0; i < 300; i++)
      begin
         rng = xs(rng);
         m = rng[23:0];
         wr(apr_pkg::ROUTE_MASK_ADDR, m);
         rng = xs(rng);
         wr((rng[7:0] == 8'h27) ? 8'h28 : rng[7:0], rng[31:8]);
         rd(apr_pkg::ROUTE_MASK_ADDR, m & 24'hfffffe);
         rd((rng[15:8] == 8'h27) ? 8'h26 : rng[15:8], 24'h000000);
         rng = xs(rng);
         c = rng[23:0];
         func = rng[31];
         drive_cond(c);
         tick;
         `CHK(alert_seen, exp_alert(m, c, func))
      end
      // ------------------------------------------------------------
      // conversion-complete pulse
      // ------------------------------------------------------------
      drive_cond(24'h000000);
      func = 1'b1;
      wr(apr_pkg::ROUTE_MASK_ADDR, 24'h000002);
      pulse_count(hi_cnt);
      `CHK(hi_cnt, apr_pkg::CONV_PULSE_CYC)
      func = 1'b0;
      pulse_count(hi_cnt);
      `CHK(hi_cnt, 7'h00)
      func = 1'b1;
      wr(apr_pkg::ROUTE_MASK_ADDR, 24'h000000);
      pulse_count(hi_cnt);
      `CHK(hi_cnt, 7'h00)
      wr(apr_pkg::ROUTE_MASK_ADDR, 24'h000002);
      conv_done = 1'b1;
      tick;
      conv_done = 1'b0;
      repeat (10) tick;
      `CHK(alert_seen, 1'b1)
      func = 1'b0;
      tick;
      `CHK(alert_seen, 1'b0)
      // ------------------------------------------------------------
      // slow input only in slow function
      // ------------------------------------------------------------
      repeat (2) tick;
      `CHK(slow_req, 1'b1)
      host_low = 1'b1;
      repeat (2) tick;
      `CHK(slow_req, 1'b0)
      host_low = 1'b0;
      func = 1'b1;
      repeat (2) tick;
      `CHK(slow_req, 1'b0)
      // ------------------------------------------------------------
      // reset in mid-run with everything routed and tripped
      // ------------------------------------------------------------
      wr(apr_pkg::ROUTE_MASK_ADDR, 24'hfffffe);
      drive_cond(24'hffffff);
      tick;
      `CHK(alert_seen, 1'b1)
      reset_n = 1'b0;
      repeat (2) tick;
      `CHK(alert_seen, 1'b0)
      reset_n = 1'b1;
      rd(apr_pkg::ROUTE_MASK_ADDR, apr_pkg::ROUTE_MASK_RESET);
      `CHK(alert_seen, 1'b0)
      drive_cond(24'h000000);
      end_sim;
   end
endmodule // test_alert1_pin_routing_mask

`default_nettype wire
